// ### hdl/vip_pkg.sv
package vip_pkg;
   localparam int          VIP_AW       = 8;
   localparam int          VIP_NSRC     = 15;
   // register byte offsets
   localparam logic [7:0]  VIP_OFF_CTRL = 8'h00;
   localparam logic [7:0]  VIP_OFF_TEN  = 8'h04;
   localparam logic [7:0]  VIP_OFF_MEN  = 8'h08;
   localparam logic [7:0]  VIP_OFF_PRIO = 8'h0C;
   localparam logic [7:0]  VIP_OFF_VEC  = 8'h10;
   localparam logic [7:0]  VIP_OFF_STAT = 8'h14;
   localparam logic [7:0]  VIP_OFF_CLR  = 8'h18;
   localparam logic [7:0]  VIP_OFF_IEN  = 8'h1C;
   // control fields, vector register valid bit, timer overflow source bit
   localparam int          VIP_CME_BIT  = 0;
   localparam int          VIP_CLK_MONITOR_FORCE_EN_BIT = 1;
   localparam int          VIP_SYNC_BIT = 2;
   localparam int          VIP_VLD_BIT  = 16;
   localparam int          VIP_TOVF_BIT = 8;
   // status event bits
   localparam int          VIP_EV_CM    = 0;
   localparam int          VIP_EV_XIRQ  = 1;
   localparam int          VIP_EV_MISU  = 2;
   localparam int          VIP_NEV      = 3;
   // reset values
   localparam logic [2:0]  VIP_CTRL_RST = 3'h0;
   localparam logic [14:0] VIP_EN_RST   = 15'h0000;
   localparam logic [7:0]  VIP_PRIO_RST = 8'h00;
   localparam logic [2:0]  VIP_IEN_RST  = 3'h0;
   // vectors
   localparam logic [7:0]  VIP_PAGE     = 8'hFF;
   localparam logic [15:0] VIP_VEC_CM   = 16'hFFFC;
   localparam logic [15:0] VIP_VEC_XIRQ = 16'hFFF4;
   localparam logic [15:0] VIP_VEC_CH0  = 16'hFFEE;
   localparam logic [15:0] VIP_VEC_RXF  = 16'hFFA6;
   // vector low bytes, index 0 = highest default priority
   localparam logic [14:0][7:0] VIP_VEC_LO = {
      8'hA6, 8'hC4, 8'hC8, 8'hCA, 8'hDA, 8'hDC, 8'hDE,
      8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, VIP_VEC_CH0[7:0]};
   localparam logic [1:0]  VIP_OKAY     = 2'h0;
   localparam logic [1:0]  VIP_SLVERR   = 2'h2;

   typedef struct packed {
      logic       rx_fifo;
      logic       self_clk;
      logic       pa_b_ovf;
      logic       mdc_unf;
      logic       pa_edge;
      logic       pa_a_ovf;
      logic       tmr_ovf;
      logic [7:0] tmr_ch;
   } vip_src_t;

   typedef struct packed {
      logic        en;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } vip_wr_t;
endpackage : vip_pkg

// ### hdl/vip_axil.sv
`timescale 1ns/10ps
`default_nettype none
module vip_axil (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic [vip_pkg::VIP_AW-1:0]  awaddr_i,
   input  wire logic                        awvalid_i,
   output logic                             awready_o,
   input  wire logic [31:0]                 wdata_i,
   input  wire logic [3:0]                  wstrb_i,
   input  wire logic                        wvalid_i,
   output logic                             wready_o,
   output logic [1:0]                       bresp_o,
   output logic                             bvalid_o,
   input  wire logic                        bready_i,
   input  wire logic [vip_pkg::VIP_AW-1:0]  araddr_i,
   input  wire logic                        arvalid_i,
   output logic                             arready_o,
   output logic [31:0]                      rdata_o,
   output logic [1:0]                       rresp_o,
   output logic                             rvalid_o,
   input  wire logic                        rready_i,
   output vip_pkg::vip_wr_t                 wr_o,
   input  wire logic                        wr_ok_i,
   input  wire logic [31:0]                 rd_data_i,
   input  wire logic                        rd_ok_i
);
   import vip_pkg::*;
   logic       aw_held_r, w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   // address and data may arrive in either order; both held until paired
   assign awready_o = !aw_held_r && !bvalid_o;
   assign wready_o  = !w_held_r && !bvalid_o;
   assign arready_o = !rvalid_o;
   wire aw_fire = awvalid_i && awready_o;
   wire w_fire  = wvalid_i && wready_o;
   wire do_wr   = (aw_held_r || aw_fire) && (w_held_r || w_fire);
   assign wr_o.en   = do_wr;
   assign wr_o.addr = aw_held_r ? awaddr_r : awaddr_i;
   assign wr_o.data = w_held_r ? wdata_r : wdata_i;
   assign wr_o.strb = w_held_r ? wstrb_r : wstrb_i;
   wire ar_fire = arvalid_i && arready_o;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         bvalid_o  <= 1'b0;
         bresp_o   <= VIP_OKAY;
      end else begin
         if (aw_fire) awaddr_r <= awaddr_i;
         if (w_fire) begin
            wdata_r <= wdata_i;
            wstrb_r <= wstrb_i;
         end
         aw_held_r <= !do_wr && (aw_held_r || aw_fire);
         w_held_r  <= !do_wr && (w_held_r || w_fire);
         if (do_wr) begin
            bvalid_o <= 1'b1;
            bresp_o  <= wr_ok_i ? VIP_OKAY : VIP_SLVERR;
         end else if (bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= 32'h0;
         rresp_o  <= VIP_OKAY;
      end else if (ar_fire) begin
         rvalid_o <= 1'b1;
         rdata_o  <= rd_data_i;
         rresp_o  <= rd_ok_i ? VIP_OKAY : VIP_SLVERR;
      end else if (rready_i) begin
         rvalid_o <= 1'b0;
      end
   end
endmodule : vip_axil
`default_nettype wire

// ### hdl/vip_prio.sv
`timescale 1ns/10ps
`default_nettype none
module vip_prio #(
   parameter int N = 15
) (
   input  wire logic [N-1:0]      req_i,
   input  wire logic [N-1:0][7:0] tab_i,
   input  wire logic [7:0]        elev_i,
   output logic                   valid_o,
   output logic                   elev_hit_o,
   output logic [7:0]             lo_o
);
   logic [7:0] fixed_lo;
   always_comb begin
      fixed_lo   = 8'h00;
      elev_hit_o = 1'b0;
      // scan downward so the lowest index, highest vector, is left standing
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            fixed_lo = tab_i[i];
         end
      end
      for (int i = 0; i < N; i++) begin
         if (req_i[i] && tab_i[i] == elev_i) begin
            elev_hit_o = 1'b1;
         end
      end
   end
   assign valid_o = |req_i;
   assign lo_o    = elev_hit_o ? elev_i : fixed_lo;
endmodule : vip_prio
`default_nettype wire

// ### hdl/vip_top.sv
// Functional notes
// - higher vector address wins by default
// - clock monitor fail resets via FFFC, unmaskable
// - external request vectors FFF4, X-bit masked only
// - eight timer channels, I-masked, FFEE down
// - timer overflow at FFDE, elevate DE
// - accumulator A overflow at FFDC, elevate DC
// - accumulator edge at FFDA, elevate DA
// - modulus underflow at FFCA, elevate CA
// - accumulator B overflow at FFC8, elevate C8
// - receive FIFO not empty at FFA6
`timescale 1ns/10ps
`default_nettype none
module vip_top (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic [vip_pkg::VIP_AW-1:0]  awaddr_i,
   input  wire logic                        awvalid_i,
   output logic                             awready_o,
   input  wire logic [31:0]                 wdata_i,
   input  wire logic [3:0]                  wstrb_i,
   input  wire logic                        wvalid_i,
   output logic                             wready_o,
   output logic [1:0]                       bresp_o,
   output logic                             bvalid_o,
   input  wire logic                        bready_i,
   input  wire logic [vip_pkg::VIP_AW-1:0]  araddr_i,
   input  wire logic                        arvalid_i,
   output logic                             arready_o,
   output logic [31:0]                      rdata_o,
   output logic [1:0]                       rresp_o,
   output logic                             rvalid_o,
   input  wire logic                        rready_i,
   input  wire vip_pkg::vip_src_t           src_flag_i,
   input  wire logic                        clk_fail_i,
   input  wire logic                        xirq_pin_i,
   input  wire logic                        sync_pulse_i,
   input  wire logic                        i_bit_i,
   input  wire logic                        x_bit_i,
   output logic [15:0]                      vector_o,
   output logic                             vec_valid_o,
   output logic                             cm_reset_o,
   output logic                             irq_o
);
   import vip_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [2:0]          ctrl_r;
   vip_src_t            en_r;
   logic [7:0]          prio_r;
   logic [VIP_NEV-1:0]  stat_r, stat_nxt, ien_r;
   logic [1:0]          xsync_r;
   logic                cm_req_q, xirq_req_q;
   vip_wr_t             wr;
   logic [31:0]         rd_data, wmask;
   logic                wr_ok, rd_ok;

   vip_axil u_axil (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .awaddr_i  (awaddr_i),
      .awvalid_i (awvalid_i),
      .awready_o (awready_o),
      .wdata_i   (wdata_i),
      .wstrb_i   (wstrb_i),
      .wvalid_i  (wvalid_i),
      .wready_o  (wready_o),
      .bresp_o   (bresp_o),
      .bvalid_o  (bvalid_o),
      .bready_i  (bready_i),
      .araddr_i  (araddr_i),
      .arvalid_i (arvalid_i),
      .arready_o (arready_o),
      .rdata_o   (rdata_o),
      .rresp_o   (rresp_o),
      .rvalid_o  (rvalid_o),
      .rready_i  (rready_i),
      .wr_o      (wr),
      .wr_ok_i   (wr_ok),
      .rd_data_i (rd_data),
      .rd_ok_i   (rd_ok)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire wa_ctrl = wr.addr == VIP_OFF_CTRL;
   wire wa_ten  = wr.addr == VIP_OFF_TEN;
   wire wa_men  = wr.addr == VIP_OFF_MEN;
   wire wa_prio = wr.addr == VIP_OFF_PRIO;
   wire wa_clr  = wr.addr == VIP_OFF_CLR;
   wire wa_ien  = wr.addr == VIP_OFF_IEN;
   assign wr_ok = wa_ctrl | wa_ten | wa_men | wa_prio | wa_clr | wa_ien;
   assign wmask = {{8{wr.strb[3]}}, {8{wr.strb[2]}}, {8{wr.strb[1]}}, {8{wr.strb[0]}}};
   wire [31:0] wmix_ctrl = ({29'h0, ctrl_r} & ~wmask) | (wr.data & wmask);
   wire [31:0] wmix_ten  = ({23'h0, en_r[8:0]} & ~wmask) | (wr.data & wmask);
   wire [31:0] wmix_men  = ({26'h0, en_r[14:9]} & ~wmask) | (wr.data & wmask);
   wire [31:0] wmix_ien  = ({29'h0, ien_r} & ~wmask) | (wr.data & wmask);
   wire        prio_we   = wr.en && wa_prio && wr.strb[0];
   wire        clr_we    = wr.en && wa_clr && wr.strb[0];

   ////////////////////////////////////////////////////////////////////////
   // request gating
   logic [VIP_NSRC-1:0] mreq;
   wire [VIP_NSRC-1:0]  flag_v = src_flag_i;
   wire [VIP_NSRC-1:0]  en_v   = en_r;
   // per source: flag and local enable, all under the I bit
   genvar g;
   generate
      for (g = 0; g < VIP_NSRC; g++) begin : g_src
         assign mreq[g] = flag_v[g] && en_v[g] && !i_bit_i;
      end
   endgenerate

   wire cm_req   = clk_fail_i && (ctrl_r[VIP_CME_BIT] || ctrl_r[VIP_CLK_MONITOR_FORCE_EN_BIT]);
   wire xsrc     = xsync_r[1] || (sync_pulse_i && ctrl_r[VIP_SYNC_BIT]);
   wire xirq_req = xsrc && !x_bit_i;

   logic       m_valid, elev_hit;
   logic [7:0] m_lo;
   vip_prio #(.N(VIP_NSRC)) u_prio (
      .req_i      (mreq),
      .tab_i      (VIP_VEC_LO),
      .elev_i     (prio_r),
      .valid_o    (m_valid),
      .elev_hit_o (elev_hit),
      .lo_o       (m_lo)
   );

   // nonmaskable first, then external, then maskable
   wire [15:0] vec_nxt = cm_req   ? VIP_VEC_CM :
                         xirq_req ? VIP_VEC_XIRQ :
                         m_valid  ? {VIP_PAGE, m_lo} : 16'h0000;
   wire        vld_nxt = cm_req || xirq_req || m_valid;

   // elevation to a value outside the table, or while unmasked
   logic in_tab;
   always_comb begin
      in_tab = 1'b0;
      for (int i = 0; i < VIP_NSRC; i++) begin
         if (VIP_VEC_LO[i] == wr.data[7:0]) in_tab = 1'b1;
      end
   end
   wire misuse = prio_we && (!in_tab || !i_bit_i);

   ////////////////////////////////////////////////////////////////////////
   // status: a new event wins over a clear in the same cycle
   wire [VIP_NEV-1:0] ev = {misuse, xirq_req && !xirq_req_q, cm_req && !cm_req_q};
   assign stat_nxt = (stat_r & ~(clr_we ? wr.data[VIP_NEV-1:0] : '0)) | ev;
   assign irq_o    = |(stat_r & ien_r);

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0;
      case (araddr_i)
         VIP_OFF_CTRL: rd_data = {29'h0, ctrl_r};
         VIP_OFF_TEN:  rd_data = {23'h0, en_r[8:0]};
         VIP_OFF_MEN:  rd_data = {26'h0, en_r[14:9]};
         VIP_OFF_PRIO: rd_data = {24'h0, prio_r};
         VIP_OFF_VEC:  rd_data = {15'h0, vec_valid_o, vector_o};
         VIP_OFF_STAT: rd_data = {29'h0, stat_r};
         VIP_OFF_CLR:  rd_data = 32'h0;
         VIP_OFF_IEN:  rd_data = {29'h0, ien_r};
         default:      rd_ok   = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= VIP_CTRL_RST;
         en_r   <= VIP_EN_RST;
         prio_r <= VIP_PRIO_RST;
         ien_r  <= VIP_IEN_RST;
      end else if (wr.en) begin
         if (wa_ctrl) ctrl_r <= wmix_ctrl[2:0];
         if (wa_ten)  en_r[8:0] <= wmix_ten[8:0];
         if (wa_men)  en_r[14:9] <= wmix_men[5:0];
         if (prio_we) prio_r <= wr.data[7:0];
         if (wa_ien)  ien_r <= wmix_ien[VIP_NEV-1:0];
      end
   end

   // external pin passes two flops before use
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         xsync_r     <= 2'b00;
         cm_req_q    <= 1'b0;
         xirq_req_q  <= 1'b0;
         stat_r      <= '0;
         vector_o    <= 16'h0000;
         vec_valid_o <= 1'b0;
         cm_reset_o  <= 1'b0;
      end else begin
         xsync_r     <= {xsync_r[0], xirq_pin_i};
         cm_req_q    <= cm_req;
         xirq_req_q  <= xirq_req;
         stat_r      <= stat_nxt;
         vector_o    <= vec_nxt;
         vec_valid_o <= vld_nxt;
         cm_reset_o  <= cm_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_cm_vector_wins: assert property (cm_req |=> vector_o == VIP_VEC_CM && cm_reset_o)
      else $error("clock monitor vector not presented");
   a_cm_gate_off: assert property (!ctrl_r[VIP_CME_BIT] && !ctrl_r[VIP_CLK_MONITOR_FORCE_EN_BIT]
      |=> vector_o != VIP_VEC_CM)
      else $error("clock monitor fired while disabled");
   a_xirq_x_mask: assert property (x_bit_i && !cm_req |=> vector_o != VIP_VEC_XIRQ)
      else $error("external request passed the X mask");
   a_xirq_over_i: assert property (xirq_req && !cm_req |=> vector_o == VIP_VEC_XIRQ)
      else $error("external request lost to a maskable one");
   a_i_bit_mask: assert property (i_bit_i && !cm_req && !xirq_req |=> !vec_valid_o)
      else $error("maskable vector with I bit set");
   a_ch0_top: assert property (mreq[0] && !cm_req && !xirq_req && !elev_hit
      |=> vector_o == VIP_VEC_CH0)
      else $error("timer channel 0 lost default priority");
   a_elev_wins: assert property (elev_hit && !cm_req && !xirq_req
      |=> vector_o == {VIP_PAGE, $past(prio_r)})
      else $error("elevated source not chosen");
   a_rx_lowest: assert property (mreq[14] && |mreq[13:0] && !elev_hit && !cm_req
      |=> vector_o != VIP_VEC_RXF)
      else $error("receive FIFO beat a higher source");
   a_tovf_vector: assert property (mreq[VIP_TOVF_BIT] && mreq[13:0] == 14'h0100
      && !elev_hit && !cm_req && !xirq_req |=> vector_o == {VIP_PAGE, VIP_VEC_LO[8]})
      else $error("timer overflow vector wrong");
   a_misuse_flag: assert property (misuse |=> stat_r[VIP_EV_MISU] ##1 stat_r[VIP_EV_MISU]
      || $past(clr_we))
      else $error("elevation misuse not recorded");

   c_cm_reset: cover property (cm_req ##1 cm_reset_o);
   c_xirq:     cover property (xirq_req ##1 vector_o == VIP_VEC_XIRQ);
   c_elevated: cover property (elev_hit && $countones(mreq) > 1);
   c_irq:      cover property (irq_o);
endmodule : vip_top
`default_nettype wire

// ### tb/vip_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// cpu mask bits and peripheral request lines, one register stage like real sources
module vip_core_model (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire vip_pkg::vip_src_t flag_req_i,
   input  wire logic [3:0]        ctl_req_i,
   input  wire logic              i_req_i,
   input  wire logic              vec_valid_i,
   output vip_pkg::vip_src_t      src_flag_o,
   output logic [3:0]             ctl_o,
   output logic                   i_bit_o,
   output logic [7:0]             fetch_cnt_o
);
   import vip_pkg::*;
   logic vld_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         src_flag_o  <= '0;
         ctl_o       <= 4'h1;
         i_bit_o     <= 1'b1;   // masked out of reset, so elevation writes are legal
         fetch_cnt_o <= 8'h00;
         vld_r       <= 1'b0;
      end else begin
         src_flag_o <= flag_req_i;
         ctl_o      <= ctl_req_i;
         i_bit_o    <= i_req_i;
         vld_r      <= vec_valid_i;
         if (vec_valid_i && !vld_r) begin
            fetch_cnt_o <= fetch_cnt_o + 8'h01;
         end
      end
   end
endmodule : vip_core_model
`default_nettype wire

// ### tb/tb_vectored_interrupt_priority.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vectored_interrupt_priority;
   import vip_pkg::*;
   logic        clk_i   = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'hF;
   logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [1:0]  bresp_o, rresp_o, rsp;
   logic [31:0] rdata_o, rd;
   vip_src_t    flag_req = '0;
   vip_src_t    src_flag;
   logic [3:0]  ctl_req  = 4'h1;
   logic [3:0]  ctl;
   logic        i_req    = 1'b1;
   logic        i_bit, vec_valid_o, cm_reset_o, irq_o;
   logic [15:0] vector_o;
   logic [7:0]  fetch_cnt;
   int          n_fail   = 0;
   int          checked  = 0;
   // winning low byte per source bit, highest vector first
   logic [7:0]  lo_tab [15] = '{8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0,
                                8'hDE, 8'hDC, 8'hDA, 8'hCA, 8'hC8, 8'hC4, 8'hA6};

   always #10 clk_i = ~clk_i;

   vip_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready_o), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o), .rdata_o(rdata_o),
      .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready), .src_flag_i(src_flag),
      .clk_fail_i(ctl[3]), .xirq_pin_i(ctl[2]), .sync_pulse_i(ctl[1]), .i_bit_i(i_bit),
      .x_bit_i(ctl[0]), .vector_o(vector_o), .vec_valid_o(vec_valid_o),
      .cm_reset_o(cm_reset_o), .irq_o(irq_o));

   vip_core_model model_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .flag_req_i(flag_req),
      .ctl_req_i(ctl_req), .i_req_i(i_req), .vec_valid_i(vec_valid_o),
      .src_flag_o(src_flag), .ctl_o(ctl), .i_bit_o(i_bit), .fetch_cnt_o(fetch_cnt));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic hang(input string what);
      n_fail++;
      $display("BAD %0t no answer to %s", $time, what);
      finish_test();
   endtask : hang

   // handshakes are sampled at the falling edge, acted on at the next rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      b_hs = 1'b0;
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40 && !b_hs; n++) begin
         @(negedge clk_i);
         aw_hs = awvalid & awready_o;
         w_hs  = wvalid & wready_o;
         b_hs  = bready & bvalid_o;
         rsp   = bresp_o;
         @(posedge clk_i);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) bready <= 1'b0;
      end
      if (!b_hs) hang("write");
      @(posedge clk_i);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      logic ar_hs, r_hs;
      r_hs = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40 && !r_hs; n++) begin
         @(negedge clk_i);
         ar_hs = arvalid & arready_o;
         r_hs  = rready & rvalid_o;
         d     = rdata_o;
         rsp   = rresp_o;
         @(posedge clk_i);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) rready <= 1'b0;
      end
      if (!r_hs) hang("read");
      @(posedge clk_i);
   endtask : axi_rd

   // one model stage, one design stage, two pin sync stages
   task automatic vchk(input logic [15:0] exp, input string what);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      cmp({16'h0, vector_o}, {16'h0, exp}, what);
      cmp({31'h0, vec_valid_o}, {31'h0, exp != 16'h0}, what);
      cmp({31'h0, cm_reset_o}, {31'h0, exp == VIP_VEC_CM}, what);
      @(posedge clk_i);
   endtask : vchk

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_rd(a, rd);
      cmp(rd, exp, what);
   endtask : rchk

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      rchk(VIP_OFF_PRIO, 32'h0, "prio reset");
      rchk(VIP_OFF_TEN, 32'h0, "enable reset");
      rchk(8'h24, 32'h0, "unmapped data");
      cmp({30'h0, rsp}, {30'h0, VIP_SLVERR}, "unmapped resp");
      axi_wr(VIP_OFF_TEN, 32'h0000_01FF);
      axi_wr(VIP_OFF_MEN, 32'h0000_003F);
      flag_req <= vip_src_t'(15'h7FFF);
      vchk(16'h0000, "i bit masks all");
      i_req <= 1'b0;
      vchk(16'hFFEE, "default order");
      // each source against the lowest one
      for (int k = 0; k < 15; k++) begin
         flag_req <= vip_src_t'((15'h0001 << k) | 15'h4000);
         vchk({8'hFF, lo_tab[k]}, "fixed vector");
      end
      axi_wr(VIP_OFF_MEN, 32'h0000_001F);
      vchk(16'h0000, "local enable off");
      axi_wr(VIP_OFF_MEN, 32'h0000_003F);
      flag_req <= vip_src_t'(15'h7FFF);
      for (int k = 0; k < 15; k++) begin
         i_req <= 1'b1;
         repeat (2) @(posedge clk_i);
         axi_wr(VIP_OFF_PRIO, {24'h0, lo_tab[k]});
         i_req <= 1'b0;
         vchk({8'hFF, lo_tab[k]}, "elevated");
      end
      rchk(VIP_OFF_STAT, 32'h0, "no misuse");
      axi_wr(VIP_OFF_PRIO, 32'h0);
      rchk(VIP_OFF_STAT, 32'h4, "misuse seen");
      axi_wr(VIP_OFF_CLR, 32'h4);
      rchk(VIP_OFF_STAT, 32'h0, "misuse cleared");
      // external request and its shared sync pulse
      axi_wr(VIP_OFF_IEN, 32'h2);
      ctl_req <= 4'h2;
      vchk(16'hFFEE, "sync not enabled");
      axi_wr(VIP_OFF_CTRL, 32'h4);
      vchk(16'hFFF4, "sync pulse");
      cmp({31'h0, irq_o}, 32'h1, "irq raised");
      ctl_req <= 4'h3;
      vchk(16'hFFEE, "x bit masks");
      ctl_req <= 4'h4;
      i_req   <= 1'b1;
      vchk(16'hFFF4, "pin, i bit set");
      ctl_req <= 4'h0;
      i_req   <= 1'b0;
      rchk(VIP_OFF_STAT, 32'h2, "external event");
      axi_wr(VIP_OFF_CLR, 32'h2);
      cmp({31'h0, irq_o}, 32'h0, "irq cleared");
      // clock monitor reset
      ctl_req <= 4'hC;
      vchk(16'hFFF4, "monitor off");
      axi_wr(VIP_OFF_CTRL, 32'h1);
      vchk(16'hFFFC, "monitor fail");
      rchk(VIP_OFF_VEC, 32'h0001_FFFC, "vector register");
      // the pin rose again with the monitor, so its event is pending too
      axi_wr(VIP_OFF_CLR, 32'h2);
      cmp({31'h0, irq_o}, 32'h0, "event masked");
      axi_wr(VIP_OFF_IEN, 32'h1);
      cmp({31'h0, irq_o}, 32'h1, "event enabled");
      axi_wr(VIP_OFF_CTRL, 32'h2);
      ctl_req <= 4'h9;
      i_req   <= 1'b1;
      vchk(16'hFFFC, "forced, masks set");
      cmp({31'h0, fetch_cnt != 8'h00}, 32'h1, "core fetched");
      finish_test();
   end
endmodule : tb_vectored_interrupt_priority
`default_nettype wire
